// [hdl/mas_pkg.sv]
// Constants for the accumulator shift and configuration block.
package mas_pkg;
  // Accumulator and register widths.
  localparam int ACC_W  = 40;
  localparam int BYTE_W = 8;
  localparam int RND_W  = 16;
  localparam int STAT_W = 4;
  localparam int ACC_BYTES = 5;

  // Configuration register field positions.
  localparam int CFG_SHIFT_GO  = 5;
  localparam int CFG_SHIFT_DIR = 4;
  localparam int CFG_CLEAR_ALL = 3;
  localparam int CFG_SAT       = 2;
  localparam int CFG_FRAC      = 1;
  localparam int CFG_MULT_ONLY = 0;

  // Reset values.
  localparam logic [7:0]        CFG_RST  = 8'h00;
  localparam logic [STAT_W-1:0] STAT_RST = 4'h4;
  localparam logic [ACC_W-1:0]  ACC_RST  = 40'h00_0000_0000;
  localparam logic [RND_W-1:0]  RND_RST  = 16'h0000;

  // Rounding thresholds and saturation limits.
  localparam logic [15:0] RND_HALF = 16'h8000;
  localparam logic [15:0] SAT_POS  = 16'h7fff;
  localparam logic [15:0] SAT_NEG  = 16'h8000;
endpackage : mas_pkg

// [hdl/mas_round.sv]
// Unbiased rounding engine with optional saturation of the 16-bit result.
`timescale 1ns/1ps
module mas_round (
  input  wire logic [39:0] acc,
  input  wire logic        sat_en,
  output logic      [15:0] rnd
);
  logic [15:0] lo;
  logic [15:0] hi;
  logic        up;
  logic [16:0] sum;
  logic        ovf_pos;
  logic        ovf_neg;

  // Round half to even on bits 31..16; bits 15..0 decide the direction.
  assign lo  = acc[15:0];
  assign hi  = acc[31:16];
  assign up  = (lo > mas_pkg::RND_HALF) ||
               ((lo == mas_pkg::RND_HALF) && hi[0]);
  assign sum = {hi[15], hi} + {16'h0000, up};

  // Overflow when the upper bits disagree with the sign of the result.
  assign ovf_pos = !acc[39] && ((acc[38:31] != 8'h00) ||
                                (sum[16] != sum[15]));
  assign ovf_neg = acc[39] && (acc[38:31] != 8'hff);

  // Saturation only replaces the value; without it the sum wraps.
  assign rnd = (sat_en && ovf_pos) ? mas_pkg::SAT_POS :
               (sat_en && ovf_neg) ? mas_pkg::SAT_NEG : sum[15:0];
endmodule : mas_round

// [hdl/mas_top.sv]
// Configuration register, accumulator shifter and rounding result holder.
// Contract
// - Shift write with direction clear shifts the accumulator left once.
// - Shift result visible two cycles after the write; carries cross bytes.
// - Rounding result refreshes one cycle after the accumulator shift.
// - Back-to-back shift writes each perform their own one-bit shift.
// - Right shifts are arithmetic, filling the top bit with the sign.
// - Shift takes one cycle, rounding one more, then shift bit self-clears.
// - Direction bit zero shifts left, one shifts right, sign from bit 39.
// - Shifts leave every status flag unchanged.
`timescale 1ns/1ps
module mas_top (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        CFG_WE,
  input  wire logic [4:0]  ACC_WE,
  input  wire logic        STAT_WE,
  input  wire logic [7:0]  SFR_WDATA,
  output logic      [7:0]  CFG_RDATA,
  output logic      [39:0] ACC_Q,
  output logic      [7:0]  STAT_RDATA,
  output logic      [15:0] RND_Q,
  output logic             SAT_EN,
  output logic             FRAC_MODE,
  output logic             MULT_ONLY
);
  logic [7:0]  cfg_q;
  logic [7:0]  cfg_d;
  logic [39:0] acc_q;
  logic [39:0] acc_d;
  logic [3:0]  stat_q;
  logic [3:0]  stat_d;
  logic [15:0] rnd_q;
  logic [15:0] rnd_d;
  logic [15:0] rnd_calc;
  logic        shift_go_q;
  logic        shift_dir_q;
  logic        round_go_q;
  logic        clr_go_q;
  logic        shift_req;
  logic        clr_req;
  logic        acc_wr_any;
  logic [39:0] acc_left;
  logic [39:0] acc_right;
  logic [39:0] acc_bytes;

  // Request decode from a configuration write.
  assign shift_req  = CFG_WE && SFR_WDATA[mas_pkg::CFG_SHIFT_GO];
  assign clr_req    = CFG_WE && SFR_WDATA[mas_pkg::CFG_CLEAR_ALL];
  assign acc_wr_any = |ACC_WE;

  // left shift: the whole word moves so carries cross byte edges.
  assign acc_left  = {acc_q[38:0], 1'b0};
  // arithmetic right: bit 39 is copied into the vacated position.
  assign acc_right = {acc_q[39], acc_q[39:1]};

  // Byte lanes for direct accumulator loads by software.
  genvar gi;
  generate
    for (gi = 0; gi < mas_pkg::ACC_BYTES; gi++) begin : g_lane
      assign acc_bytes[gi*8 +: 8] = ACC_WE[gi] ? SFR_WDATA
                                               : acc_q[gi*8 +: 8];
    end
  endgenerate

  // Next accumulator: clear-all beats loads, loads beat a pending shift.
  always_comb begin
    acc_d = acc_q;
    if (clr_go_q) begin
      acc_d = mas_pkg::ACC_RST;
    end else if (acc_wr_any) begin
      acc_d = acc_bytes;
    end else if (shift_go_q) begin
      acc_d = shift_dir_q ? acc_right : acc_left;
    end
  end

  // Next configuration: self-clearing bits drop once their work is done.
  always_comb begin
    cfg_d = cfg_q;
    if (round_go_q && !shift_go_q) begin
      // shift bit clears after the rounding cycle.
      cfg_d[mas_pkg::CFG_SHIFT_GO] = 1'b0;
    end
    if (clr_go_q) begin
      cfg_d[mas_pkg::CFG_CLEAR_ALL] = 1'b0;
    end
    if (CFG_WE) begin
      // only bits 5..0 store; a write wins over a self-clear.
      cfg_d = {2'b00, SFR_WDATA[5:0]};
    end
  end

  // status only changes by clear-all or a direct software write.
  always_comb begin
    stat_d = stat_q;
    if (STAT_WE) begin
      stat_d = SFR_WDATA[3:0];
    end
    if (clr_go_q) begin
      stat_d = mas_pkg::STAT_RST;
    end
  end

  // rounding result taken one cycle behind the accumulator.
  assign rnd_d = round_go_q ? rnd_calc : rnd_q;

  mas_round u_round (
    .acc    (acc_q),
    .sat_en (cfg_q[mas_pkg::CFG_SAT]),
    .rnd    (rnd_calc)
  );

  // Pipeline strobes: each write makes its own shift pulse.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      shift_go_q  <= 1'b0;
      shift_dir_q <= 1'b0;
      round_go_q  <= 1'b0;
      clr_go_q    <= 1'b0;
    end else begin
      // one pulse per write, so consecutive writes give two shifts.
      shift_go_q  <= shift_req;
      shift_dir_q <= SFR_WDATA[mas_pkg::CFG_SHIFT_DIR];
      round_go_q  <= shift_go_q || ACC_WE[0];
      clr_go_q    <= clr_req;
    end
  end

  // State registers.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q  <= mas_pkg::CFG_RST;
      acc_q  <= mas_pkg::ACC_RST;
      stat_q <= mas_pkg::STAT_RST;
      rnd_q  <= mas_pkg::RND_RST;
    end else begin
      cfg_q  <= cfg_d;
      acc_q  <= acc_d;
      stat_q <= stat_d;
      rnd_q  <= rnd_d;
    end
  end

  // Read-back and mode outputs, all straight from flip-flops.
  assign CFG_RDATA  = cfg_q;
  assign ACC_Q      = acc_q;
  assign STAT_RDATA = {4'h0, stat_q};
  assign RND_Q      = rnd_q;
  assign SAT_EN     = cfg_q[mas_pkg::CFG_SAT];
  assign FRAC_MODE  = cfg_q[mas_pkg::CFG_FRAC];
  assign MULT_ONLY  = cfg_q[mas_pkg::CFG_MULT_ONLY];

  // Checks on the shift pipeline and the register behaviour.
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  chk_left_shift_value: assert property (
    (shift_req && !SFR_WDATA[4] && !clr_go_q) ##1
    (!acc_wr_any && !clr_go_q)
    |=> (acc_q == {$past(acc_q[38:0]), 1'b0}))
    else $error("left shift gave a wrong accumulator");

  // the shifted value is visible two cycles after the write.
  chk_shift_visible_late: assert property (
    (shift_req && !acc_wr_any && !clr_go_q) ##1
    (!acc_wr_any && !clr_go_q)
    |=> (acc_q == ($past(SFR_WDATA[mas_pkg::CFG_SHIFT_DIR], 2)
                   ? {$past(acc_q[39]), $past(acc_q[39:1])}
                   : {$past(acc_q[38:0]), 1'b0})))
    else $error("shift result not visible in time");

  // rounding follows two cycles after the shift pulse, one after the accumulator.
  chk_round_lag_one: assert property (
    shift_go_q |=> ##1 (rnd_q == $past(rnd_calc)))
    else $error("rounding did not follow the shift");

  // two consecutive writes produce two shift pulses.
  chk_two_shift_pulses: assert property (
    shift_req ##1 shift_req |=> shift_go_q && $past(shift_go_q))
    else $error("back-to-back shifts merged");

  // right shift keeps the sign and halves.
  chk_right_shift_sign: assert property (
    (shift_go_q && shift_dir_q && !acc_wr_any && !clr_go_q)
    |=> (acc_q == {$past(acc_q[39]), $past(acc_q[39:1])}))
    else $error("right shift not arithmetic");

  // shift bit clears three cycles after a lone write.
  chk_shift_bit_clears: assert property (
    (shift_req ##1 !CFG_WE [*2]) |=> !cfg_q[mas_pkg::CFG_SHIFT_GO])
    else $error("shift bit failed to self-clear");

  // direction bit zero shifts left and leaves bit 0 clear.
  chk_dir_left_sel: assert property (
    (shift_go_q && !shift_dir_q && !acc_wr_any && !clr_go_q)
    |=> (acc_q[0] == 1'b0))
    else $error("left shift filled bit 0");

  chk_status_stable: assert property (
    (shift_go_q && !STAT_WE && !clr_go_q) |=> $stable(stat_q))
    else $error("status changed during a shift");

  // clear-all zeroes the accumulator and resets status.
  chk_clear_all_effect: assert property (
    (clr_req ##1 (!acc_wr_any && !STAT_WE && !CFG_WE))
    |=> (acc_q == 40'h0) && (stat_q == mas_pkg::STAT_RST)
        && !cfg_q[mas_pkg::CFG_CLEAR_ALL])
    else $error("clear-all did not reset state");

  chk_reserved_zero: assert property (
    CFG_RDATA[7:6] == 2'b00 && STAT_RDATA[7:4] == 4'h0)
    else $error("reserved bits read non-zero");

  // Main scenarios.
  cov_left_shift: cover property (shift_go_q && !shift_dir_q);
  cov_double_right: cover property (
    (shift_go_q && shift_dir_q) ##1 (shift_go_q && shift_dir_q));
  cov_clear_all: cover property (clr_go_q);
endmodule : mas_top

// [sim/mas_top_tb.sv]
// Self-checking bench for the accumulator shift and configuration block.
`timescale 1ns/1ps
module mas_top_tb;
  typedef struct {int due; int sel; logic [39:0] e;} mas_note_t;
  logic        clk;
  logic        rst_n;
  logic        cfg_we;
  logic        stat_we;
  logic [4:0]  acc_we;
  logic [7:0]  wdata;
  logic [7:0]  cfg_rd;
  logic [7:0]  stat_rd;
  logic [39:0] acc_q;
  logic [39:0] ea;
  logic [15:0] rnd_q;
  logic        sat;
  logic        frac;
  logic        mult;
  logic [2:0]  em;
  logic [3:0]  es;
  int          cyc;
  int          n_mismatch;
  int          total_checks;
  mas_note_t   q[$];
  string       nm[5] = '{"acc", "rnd", "cfg", "stat", "mode"};

  mas_top DUT (.REF_CLK(clk), .RST_N(rst_n), .CFG_WE(cfg_we),
    .ACC_WE(acc_we), .STAT_WE(stat_we), .SFR_WDATA(wdata),
    .CFG_RDATA(cfg_rd), .ACC_Q(acc_q), .STAT_RDATA(stat_rd),
    .RND_Q(rnd_q), .SAT_EN(sat), .FRAC_MODE(frac), .MULT_ONLY(mult));

  // Free-running 10 MHz clock and an edge count used to time the notes.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input int s, input logic [39:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm[s], exp, got);
    end
  endtask : check

  // Outputs only move on rising edges, so the falling edge sees them settled.
  always @(negedge clk) begin : watch
    int          i;
    logic [39:0] got;
    i = 0;
    while (i < q.size()) begin
      if (q[i].due == cyc) begin
        case (q[i].sel)
          0: got = acc_q;
          1: got = {24'h0, rnd_q};
          2: got = {32'h0, cfg_rd};
          3: got = {32'h0, stat_rd};
          default: got = {37'h0, sat, frac, mult};
        endcase
        check(q[i].sel, got, q[i].e);
        q.delete(i);
      end else i++;
    end
  end

  task automatic note(input int dly, input int sel, input logic [39:0] e);
    q.push_back('{cyc + dly, sel, e});
  endtask : note

  // Every strobe is rewritten each cycle, so none lingers past one edge.
  task automatic pulse(input logic c, input logic [4:0] a, input logic s,
                       input logic [7:0] d);
    @(negedge clk);
    cfg_we = c;
    acc_we = a;
    stat_we = s;
    wdata = d;
  endtask : pulse

  task automatic idle(input int n);
    repeat (n) pulse(1'b0, 5'h00, 1'b0, 8'($urandom));
  endtask : idle

  // Round half to even on bits 31..16, optional clamp on overflow.
  function automatic logic [15:0] rexp(input logic [39:0] a, input logic s);
    logic        up;
    logic [15:0] r;
    up = (a[15:0] > 16'h8000) || (a[15:0] == 16'h8000 && a[16]);
    r = a[31:16] + 16'(up);
    if (s && (a[39:31] != {9{a[39]}} || (!a[39] && up && r == 16'h8000)))
      r = a[39] ? 16'h8000 : 16'h7fff;
    return r;
  endfunction : rexp

  // Bytes go top first so the byte-0 write, which refreshes rounding, is last.
  task automatic ldacc(input logic [39:0] v);
    for (int i = 4; i >= 0; i--) pulse(1'b0, 5'(1 << i), 1'b0, v[8*i +: 8]);
    ea = v;
    note(1, 0, ea);
    note(2, 1, {24'h0, rexp(ea, em[mas_pkg::CFG_SAT])});
  endtask : ldacc

  // Direction taken from each write's own data.
  task automatic shift(input logic dir, input logic lone);
    logic [7:0] d;
    d = {2'b00, 1'b1, dir, 1'b0, em};
    pulse(1'b1, 5'h00, 1'b0, d);
    ea = dir ? {ea[39], ea[39:1]} : {ea[38:0], 1'b0};
    note(2, 0, ea);
    note(3, 1, {24'h0, rexp(ea, em[mas_pkg::CFG_SAT])});
    if (lone) begin
      note(1, 2, {32'h0, d});
      note(3, 2, {32'h0, d & 8'hdf});
    end
  endtask : shift

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // A hang is cut short well beyond the few hundred cycles the run needs.
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    {rst_n, cfg_we, acc_we, stat_we, wdata} = '0;
    ea = '0;
    em = '0;
    es = 4'h4;
    void'($urandom(32'hc23e3ae0));
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    // Reset values, then every mode with the reserved bits 7..6 set.
    note(1, 0, 40'h0);
    note(1, 1, 40'h0);
    note(1, 2, 40'h0);
    note(1, 3, 40'h4);
    for (int m = 0; m < 8; m++) begin
      em = 3'(m);
      pulse(1'b1, 5'h00, 1'b0, {5'h18, em});
      note(1, 2, {37'h0, em});
      note(1, 4, {37'h0, em});
    end
    $display("test modes done");
    em = 3'h0;
    pulse(1'b1, 5'h00, 1'b0, 8'h00);
    es = 4'hb;
    pulse(1'b0, 5'h00, 1'b1, 8'h0b);
    ldacc(40'h40_8844_2211);
    shift(1'b0, 1'b1);
    idle(3);
    shift(1'b1, 1'b0);
    shift(1'b1, 1'b0);
    idle(4);
    note(1, 3, {36'h0, es});
    $display("test example done");
    repeat (24) begin
      em = 3'($urandom);
      pulse(1'b1, 5'h00, 1'b0, {5'h00, em});
      ldacc({8'($urandom), 32'($urandom)});
      if ($urandom % 2) begin
        shift(1'($urandom), 1'b0);
        shift(1'($urandom), 1'b0);
      end else shift(1'($urandom), 1'b1);
      idle(4);
    end
    note(1, 3, {36'h0, es});
    $display("test random done");
    // Clear-all zeroes the accumulator, restores status, self-clears.
    pulse(1'b1, 5'h00, 1'b0, {5'h01, em});
    note(1, 2, {32'h0, 5'h01, em});
    note(2, 2, {37'h0, em});
    note(2, 0, 40'h0);
    note(2, 3, 40'h4);
    idle(4);
    $display("test clear done");
    conclude();
  end
endmodule : mas_top_tb
